/* File: core/csi2_header_ecc.sv */
// header error correction byte over the data identifier and word count
`timescale 1ns/1ns
`default_nettype none
module csi2_header_ecc (
    input wire logic [23:0] hdr_bits,
    output logic [7:0] ecc
);
    genvar i;
    generate
        for (i = 0; i < 6; i++) begin : g_par
            assign ecc[i] = ^(hdr_bits & csi2_vc_map_pkg::ECC_MASK[i]);
        end
    endgenerate
    assign ecc[7:6] = 2'b00;
endmodule
`default_nettype wire

/* File: core/csi2_vc_datatype_mapper.sv */
// csi-2 packet labelling: channel and data type insertion, remap, merge and lane rate
`timescale 1ns/1ns
`default_nettype none
module csi2_vc_datatype_mapper #(
    parameter int REF_CLK_MHZ = csi2_vc_map_pkg::NOMINAL_REF_MHZ,
    parameter int PIX_W = csi2_vc_map_pkg::PIX_CNT_W,
    parameter logic [55:0] AUTO_TIMING_FULL = csi2_vc_map_pkg::AUTO_TIMING_FULL_DEFAULT,
    parameter logic [55:0] AUTO_TIMING_HALF = csi2_vc_map_pkg::AUTO_TIMING_HALF_DEFAULT
) (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic link_clk,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic reg_port_sel,
    output logic [7:0] reg_rdata,
    output logic reg_rvalid,
    input wire csi2_vc_map_pkg::rx_mode_e [1:0] rx_mode,
    input wire logic [1:0] csi_pkt_valid,
    output logic [1:0] csi_pkt_ready,
    input wire logic [1:0][1:0] csi_pkt_vc,
    input wire logic [1:0][5:0] csi_pkt_dt,
    input wire logic [1:0][15:0] csi_pkt_wc,
    input wire logic [1:0] raw_frame_sync,
    input wire logic [1:0] raw_line_sync,
    input wire logic [1:0] raw_pixel_valid,
    output logic [1:0] tx_lane_rate,
    output logic pll_low_ref,
    output logic [11:0] lane_rate_mbps,
    output logic [7:0] timer_ref_mhz,
    output logic [7:0][6:0] tx_timing,
    output logic tx_timing_auto,
    output logic [7:0] tx_byte,
    output logic tx_byte_valid,
    output logic tx_pkt_start,
    output logic tx_pkt_long
);

    // ************************************************
    // state
    // ************************************************
    typedef struct packed {
        logic fv;
        logic lv;
        logic [PIX_W-1:0] pix;
        logic fs_pend;
        logic ln_pend;
        logic fe_pend;
        logic [15:0] ln_wc;
        logic slot_v;
        csi2_vc_map_pkg::hdr_s slot;
    } port_s;

    typedef struct packed {
        logic [7:0] rate;
        logic [1:0][7:0] raw10;
        logic [1:0][7:0] raw12;
        logic [1:0][3:0][1:0] remap;
        logic [7:0] page;
        logic [7:0] iaddr;
        logic [7:0][7:0] timing;
        logic [7:0] rdata;
        logic rvalid;
        logic rr;
        logic [1:0] rate_o;
        logic pll_low;
        logic [11:0] mbps;
        logic [7:0][6:0] timing_o;
        logic timing_auto;
        port_s [1:0] port;
    } st_s;

    typedef struct packed {
        logic [1:0] rem;
        logic [2:0][7:0] sr;
        logic [7:0] byte_o;
        logic valid;
        logic start;
        logic long_pkt;
    } link_s;

    // full rate follows the reference clock: 1664, 1600, 1472 at 26, 25, 23 mhz
    localparam int FULL_MBPS = csi2_vc_map_pkg::NOMINAL_RATE_MBPS * REF_CLK_MHZ
        / csi2_vc_map_pkg::NOMINAL_REF_MHZ;
    localparam logic [11:0] MBPS_FULL = 12'(FULL_MBPS);
    localparam logic [7:0] REF_MHZ_8 = 8'(REF_CLK_MHZ);

    st_s st_q;
    st_s st_d;
    link_s lk_q;
    link_s lk_d;
    logic link_rst_meta_q;
    logic link_rst_b_q;
    logic sel;
    logic cdc_valid;
    logic cdc_ready;
    logic [7:0] ecc;
    csi2_vc_map_pkg::hdr_s cdc_data;
    hdr_if hs ();

    // ************************************************
    // reference clock domain
    // ************************************************
    always_comb begin
        logic tin;
        logic [2:0] tidx;
        logic [7:0] ctx;
        logic [3:0] bits;
        logic [PIX_W+3:0] prod;
        csi2_vc_map_pkg::hdr_s h;
        csi2_vc_map_pkg::rate_e rate;
        tin = (st_q.iaddr[7:3] == csi2_vc_map_pkg::IADDR_TIMING_BASE[7:3]);
        tidx = st_q.iaddr[2:0];
        ctx = 8'h00;
        bits = csi2_vc_map_pkg::BITS_RAW8;
        prod = '0;
        h = '0;
        rate = csi2_vc_map_pkg::rate_e'(st_q.rate[csi2_vc_map_pkg::RATE_MSB:0]);
        st_d = st_q;
        st_d.rvalid = 1'b0;

        // round robin between the two port slots
        sel = st_q.rr;
        if (!st_q.port[sel].slot_v) begin
            sel = ~st_q.rr;
        end
        hs.valid = st_q.port[sel].slot_v;
        hs.data = st_q.port[sel].slot;
        if (hs.valid && hs.ready) begin
            st_d.port[sel].slot_v = 1'b0;
            st_d.rr = ~sel;
        end

        // register writes and reads; a write wins over a read in the same cycle
        if (reg_wr) begin
            case (reg_addr)
                csi2_vc_map_pkg::ADDR_RATE: begin
                    st_d.rate = reg_wdata;
                end
                csi2_vc_map_pkg::ADDR_RAW10: begin
                    st_d.raw10[reg_port_sel] = reg_wdata;
                end
                csi2_vc_map_pkg::ADDR_RAW12: begin
                    st_d.raw12[reg_port_sel] = reg_wdata;
                end
                csi2_vc_map_pkg::ADDR_REMAP: begin
                    st_d.remap[reg_port_sel] = reg_wdata;
                end
                csi2_vc_map_pkg::ADDR_PAGE: begin
                    st_d.page = reg_wdata;
                end
                csi2_vc_map_pkg::ADDR_IADDR: begin
                    st_d.iaddr = reg_wdata;
                end
                csi2_vc_map_pkg::ADDR_IDATA: begin
                    if (tin) begin
                        st_d.timing[tidx] = reg_wdata;
                    end
                    if (st_q.page[csi2_vc_map_pkg::PAGE_AUTOINC_BIT]) begin
                        st_d.iaddr = st_q.iaddr + 8'h01;
                    end
                end
                default: begin
                end
            endcase
        end else if (reg_rd) begin
            st_d.rvalid = 1'b1;
            case (reg_addr)
                csi2_vc_map_pkg::ADDR_RATE: st_d.rdata = st_q.rate;
                csi2_vc_map_pkg::ADDR_RAW10: st_d.rdata = st_q.raw10[reg_port_sel];
                csi2_vc_map_pkg::ADDR_RAW12: st_d.rdata = st_q.raw12[reg_port_sel];
                csi2_vc_map_pkg::ADDR_REMAP: st_d.rdata = st_q.remap[reg_port_sel];
                csi2_vc_map_pkg::ADDR_PAGE: st_d.rdata = st_q.page;
                csi2_vc_map_pkg::ADDR_IADDR: st_d.rdata = st_q.iaddr;
                csi2_vc_map_pkg::ADDR_IDATA: begin
                    st_d.rdata = tin ? st_q.timing[tidx] : 8'h00;
                    if (st_q.page[csi2_vc_map_pkg::PAGE_AUTOINC_BIT]) begin
                        st_d.iaddr = st_q.iaddr + 8'h01;
                    end
                end
                default: st_d.rdata = 8'h00;
            endcase
        end

        // lane rate and timing selection
        st_d.rate_o = rate;
        st_d.pll_low = (rate == csi2_vc_map_pkg::RATE_QUARTER);
        case (rate)
            csi2_vc_map_pkg::RATE_HALF: st_d.mbps = MBPS_FULL >> 1;
            csi2_vc_map_pkg::RATE_QUARTER: st_d.mbps = MBPS_FULL >> 2;
            default: st_d.mbps = MBPS_FULL;
        endcase
        st_d.timing_auto = (rate == csi2_vc_map_pkg::RATE_FULL)
            || (rate == csi2_vc_map_pkg::RATE_HALF);
        for (int i = 0; i < csi2_vc_map_pkg::NUM_TIMING; i++) begin
            if (st_q.timing[i][csi2_vc_map_pkg::TIMING_OVR_BIT]) begin
                st_d.timing_o[i] = st_q.timing[i][6:0];
                st_d.timing_auto = 1'b0;
            end else if (rate == csi2_vc_map_pkg::RATE_FULL) begin
                st_d.timing_o[i] = AUTO_TIMING_FULL[i*7 +: 7];
            end else begin
                // no table for quarter or reserved: half table stands in
                st_d.timing_o[i] = AUTO_TIMING_HALF[i*7 +: 7];
            end
        end

        // per port packet building
        for (int p = 0; p < 2; p++) begin
            ctx = (rx_mode[p] == csi2_vc_map_pkg::MODE_RAW12) ? st_q.raw12[p] : st_q.raw10[p];
            case (rx_mode[p])
                csi2_vc_map_pkg::MODE_RAW10: bits = csi2_vc_map_pkg::BITS_RAW10;
                csi2_vc_map_pkg::MODE_RAW12: bits = csi2_vc_map_pkg::BITS_RAW12;
                default: bits = csi2_vc_map_pkg::BITS_RAW8;
            endcase
            h = '0;
            if (!st_d.port[p].slot_v) begin
                if (rx_mode[p] == csi2_vc_map_pkg::MODE_CSI2) begin
                    if (csi_pkt_valid[p]) begin
                        h.vc = st_q.remap[p][csi_pkt_vc[p]];
                        h.dt = csi_pkt_dt[p];
                        h.wc = csi_pkt_wc[p];
                        h.long_pkt = (h.dt > csi2_vc_map_pkg::DT_SHORT_MAX);
                        st_d.port[p].slot = h;
                        st_d.port[p].slot_v = 1'b1;
                    end
                end else if (st_q.port[p].fs_pend || st_q.port[p].ln_pend
                        || st_q.port[p].fe_pend) begin
                    h.vc = ctx[csi2_vc_map_pkg::CTX_VC_MSB:csi2_vc_map_pkg::CTX_VC_LSB];
                    if (st_q.port[p].fs_pend) begin
                        h.dt = csi2_vc_map_pkg::DT_FRAME_START;
                        st_d.port[p].fs_pend = 1'b0;
                    end else if (st_q.port[p].ln_pend) begin
                        h.dt = ctx[csi2_vc_map_pkg::CTX_DT_MSB:csi2_vc_map_pkg::CTX_DT_LSB];
                        h.wc = st_q.port[p].ln_wc;
                        st_d.port[p].ln_pend = 1'b0;
                    end else begin
                        h.dt = csi2_vc_map_pkg::DT_FRAME_END;
                        st_d.port[p].fe_pend = 1'b0;
                    end
                    h.long_pkt = (h.dt > csi2_vc_map_pkg::DT_SHORT_MAX);
                    st_d.port[p].slot = h;
                    st_d.port[p].slot_v = 1'b1;
                end
            end

            // raw framing events; a new event wins over the clear above
            st_d.port[p].fv = raw_frame_sync[p];
            st_d.port[p].lv = raw_line_sync[p];
            if (rx_mode[p] != csi2_vc_map_pkg::MODE_CSI2) begin
                if (raw_pixel_valid[p] && raw_line_sync[p]) begin
                    st_d.port[p].pix = st_q.port[p].pix + 1'b1;
                end
                if (raw_frame_sync[p] && !st_q.port[p].fv) begin
                    st_d.port[p].fs_pend = 1'b1;
                    st_d.port[p].pix = '0;
                end
                if (!raw_line_sync[p] && st_q.port[p].lv) begin
                    prod = {4'h0, st_q.port[p].pix} * {{PIX_W{1'b0}}, bits};
                    st_d.port[p].ln_wc = 16'(prod >> 3);
                    st_d.port[p].ln_pend = 1'b1;
                    st_d.port[p].pix = '0;
                end
                if (!raw_frame_sync[p] && st_q.port[p].fv) begin
                    st_d.port[p].fe_pend = 1'b1;
                end
            end
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            st_q <= '0;
            st_q.rate <= csi2_vc_map_pkg::RATE_RST;
            st_q.raw10 <= {2{csi2_vc_map_pkg::RAW_CTX_RST}};
            st_q.raw12 <= {2{csi2_vc_map_pkg::RAW_CTX_RST}};
            st_q.remap <= {2{csi2_vc_map_pkg::REMAP_RST}};
            st_q.page <= csi2_vc_map_pkg::PAGE_RST;
            st_q.iaddr <= csi2_vc_map_pkg::IADDR_RST;
            st_q.timing <= {8{csi2_vc_map_pkg::TIMING_RST}};
            st_q.mbps <= MBPS_FULL;
            st_q.timing_auto <= 1'b1;
        end else begin
            st_q <= st_d;
        end
    end

    always_comb begin
        for (int p = 0; p < 2; p++) begin
            csi_pkt_ready[p] = !st_q.port[p].slot_v
                && (rx_mode[p] == csi2_vc_map_pkg::MODE_CSI2);
        end
    end

    assign reg_rdata = st_q.rdata;
    assign reg_rvalid = st_q.rvalid;
    assign tx_lane_rate = st_q.rate_o;
    assign pll_low_ref = st_q.pll_low;
    assign lane_rate_mbps = st_q.mbps;
    assign timer_ref_mhz = REF_MHZ_8;
    assign tx_timing = st_q.timing_o;
    assign tx_timing_auto = st_q.timing_auto;

    // ************************************************
    // link clock domain
    // ************************************************
    // reset asserts at once, releases on the link clock
    always_ff @(posedge link_clk or negedge rst_b) begin
        if (!rst_b) begin
            link_rst_meta_q <= 1'b0;
            link_rst_b_q <= 1'b0;
        end else begin
            link_rst_meta_q <= 1'b1;
            link_rst_b_q <= link_rst_meta_q;
        end
    end

    hdr_word_cdc u_cdc (
        .clk(clk),
        .rst_b(rst_b),
        .in_hdr(hs.dst),
        .link_clk(link_clk),
        .link_rst_b(link_rst_b_q),
        .out_data(cdc_data),
        .out_valid(cdc_valid),
        .out_ready(cdc_ready)
    );

    csi2_header_ecc u_ecc (
        .hdr_bits({cdc_data.wc, cdc_data.vc, cdc_data.dt}),
        .ecc(ecc)
    );

    assign cdc_ready = (lk_q.rem == 2'b00);

    always_comb begin
        lk_d = lk_q;
        lk_d.start = 1'b0;
        if (lk_q.rem != 2'b00) begin
            lk_d.byte_o = lk_q.sr[0];
            lk_d.sr = {8'h00, lk_q.sr[2:1]};
            lk_d.rem = lk_q.rem - 2'b01;
            lk_d.valid = 1'b1;
        end else if (cdc_valid) begin
            lk_d.byte_o = {cdc_data.vc, cdc_data.dt};
            lk_d.sr = {ecc, cdc_data.wc[15:8], cdc_data.wc[7:0]};
            lk_d.rem = 2'b11;
            lk_d.valid = 1'b1;
            lk_d.start = 1'b1;
            lk_d.long_pkt = cdc_data.long_pkt;
        end else begin
            lk_d.valid = 1'b0;
        end
    end

    always_ff @(posedge link_clk or negedge link_rst_b_q) begin
        if (!link_rst_b_q) begin
            lk_q <= '0;
        end else begin
            lk_q <= lk_d;
        end
    end

    assign tx_byte = lk_q.byte_o;
    assign tx_byte_valid = lk_q.valid;
    assign tx_pkt_start = lk_q.start;
    assign tx_pkt_long = lk_q.long_pkt;

endmodule
`default_nettype wire

/* File: core/hdr_word_cdc.sv */
// toggle handshake crossing of header words into the link clock domain
`timescale 1ns/1ns
`default_nettype none
module hdr_word_cdc (
    input wire logic clk,
    input wire logic rst_b,
    hdr_if.dst in_hdr,
    input wire logic link_clk,
    input wire logic link_rst_b,
    output var csi2_vc_map_pkg::hdr_s out_data,
    output logic out_valid,
    input wire logic out_ready
);
    typedef struct packed {
        logic req;
        logic ack_s1;
        logic ack_s2;
        csi2_vc_map_pkg::hdr_s data;
    } src_s;

    typedef struct packed {
        logic req_s1;
        logic req_s2;
        logic ack;
        logic valid;
        csi2_vc_map_pkg::hdr_s data;
    } dst_s;

    src_s s_q;
    src_s s_d;
    dst_s d_q;
    dst_s d_d;

    // source stays busy until the far side has captured the word
    assign in_hdr.ready = (s_q.req == s_q.ack_s2);

    always_comb begin
        s_d = s_q;
        s_d.ack_s1 = d_q.ack;
        s_d.ack_s2 = s_q.ack_s1;
        if (in_hdr.valid && (s_q.req == s_q.ack_s2)) begin
            s_d.data = in_hdr.data;
            s_d.req = ~s_q.req;
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    // ************************************************
    // link side
    // ************************************************
    always_comb begin
        d_d = d_q;
        d_d.req_s1 = s_q.req;
        d_d.req_s2 = d_q.req_s1;
        if (d_q.valid && out_ready) begin
            d_d.valid = 1'b0;
        end
        // data is stable here: source holds it until the ack returns
        if (!d_q.valid && (d_q.req_s2 != d_q.ack)) begin
            d_d.data = s_q.data;
            d_d.valid = 1'b1;
            d_d.ack = d_q.req_s2;
        end
    end

    always_ff @(posedge link_clk or negedge link_rst_b) begin
        if (!link_rst_b) begin
            d_q <= '0;
        end else begin
            d_q <= d_d;
        end
    end

    assign out_valid = d_q.valid;
    assign out_data = d_q.data;
endmodule
`default_nettype wire

/* File: include/csi2_vc_map_pkg.sv */
// shared constants and types for the csi-2 channel and data type labelling block
package csi2_vc_map_pkg;

    // ************************************************
    // register offsets
    // ************************************************
    localparam logic [7:0] ADDR_RATE = 8'h1f;
    localparam logic [7:0] ADDR_RAW10 = 8'h70;
    localparam logic [7:0] ADDR_RAW12 = 8'h71;
    localparam logic [7:0] ADDR_REMAP = 8'h72;
    localparam logic [7:0] ADDR_PAGE = 8'hb0;
    localparam logic [7:0] ADDR_IADDR = 8'hb1;
    localparam logic [7:0] ADDR_IDATA = 8'hb2;
    localparam logic [7:0] IADDR_TIMING_BASE = 8'h40;

    // ************************************************
    // field positions
    // ************************************************
    localparam int CTX_VC_MSB = 7;
    localparam int CTX_VC_LSB = 6;
    localparam int CTX_DT_MSB = 5;
    localparam int CTX_DT_LSB = 0;
    localparam int PAGE_AUTOINC_BIT = 1;
    localparam int TIMING_OVR_BIT = 7;
    localparam int RATE_MSB = 1;
    localparam int NUM_TIMING = 8;

    // ************************************************
    // reset values
    // ************************************************
    localparam logic [7:0] RATE_RST = 8'h00;
    localparam logic [7:0] RAW_CTX_RST = 8'h00;
    localparam logic [7:0] REMAP_RST = 8'he4;
    localparam logic [7:0] PAGE_RST = 8'h00;
    localparam logic [7:0] IADDR_RST = 8'h00;
    localparam logic [7:0] TIMING_RST = 8'h00;

    // ************************************************
    // rates and modes
    // ************************************************
    typedef enum logic [1:0] {
        RATE_FULL = 2'b00,
        RATE_RSVD = 2'b01,
        RATE_HALF = 2'b10,
        RATE_QUARTER = 2'b11
    } rate_e;

    typedef enum logic [1:0] {MODE_CSI2, MODE_RAW8, MODE_RAW10, MODE_RAW12} rx_mode_e;

    localparam int NOMINAL_RATE_MBPS = 1600;
    localparam int NOMINAL_REF_MHZ = 25;
    localparam int PIX_CNT_W = 14;
    localparam logic [3:0] BITS_RAW8 = 4'h8;
    localparam logic [3:0] BITS_RAW10 = 4'ha;
    localparam logic [3:0] BITS_RAW12 = 4'hc;

    // plain defaults for the automatic lane timing tables
    localparam logic [55:0] AUTO_TIMING_FULL_DEFAULT = {8{7'h10}};
    localparam logic [55:0] AUTO_TIMING_HALF_DEFAULT = {8{7'h08}};

    // ************************************************
    // packet header
    // ************************************************
    localparam logic [5:0] DT_FRAME_START = 6'h00;
    localparam logic [5:0] DT_FRAME_END = 6'h01;
    localparam logic [5:0] DT_SHORT_MAX = 6'h0f;

    typedef struct packed {
        logic long_pkt;
        logic [15:0] wc;
        logic [1:0] vc;
        logic [5:0] dt;
    } hdr_s;

    // parity masks over {wc, vc, dt}, bit 0 is the first header bit
    localparam logic [5:0][23:0] ECC_MASK = {
        24'hef_fc00, 24'hdf_03f0, 24'hb8_e38e,
        24'h74_9a6d, 24'hf2_555b, 24'hf1_2cb7
    };

endpackage

/* File: include/hdr_if.sv */
// header word handshake between the labelling core and the link crossing
`timescale 1ns/1ns
`default_nettype none
interface hdr_if;
    logic valid;
    logic ready;
    csi2_vc_map_pkg::hdr_s data;
    modport src (output valid, output data, input ready);
    modport dst (input valid, input data, output ready);
endinterface
`default_nettype wire

/* File: testbench/csi2_rx_model.sv */
// far-side receiver: gathers identifier and word count of each header
`timescale 1ns/1ns
`default_nettype none
module csi2_rx_model (
    input wire logic link_clk,
    input wire logic [7:0] tx_byte,
    input wire logic tx_byte_valid,
    input wire logic tx_pkt_start,
    output logic [23:0] hdr,
    output logic [7:0] ecc,
    output logic [7:0] pkts
);
    logic [1:0] idx = 2'h0;
    logic [23:0] acc = 24'h00_0000;
    initial pkts = 8'h00;
    always @(posedge link_clk) begin
        if (tx_byte_valid && tx_pkt_start) begin
            acc[7:0] <= tx_byte;
            idx <= 2'h1;
        end else if (tx_byte_valid) begin
            if (idx == 2'h1) acc[15:8] <= tx_byte;
            if (idx == 2'h2) acc[23:16] <= tx_byte;
            if (idx == 2'h3) hdr <= acc;
            if (idx == 2'h3) ecc <= tx_byte;
            if (idx == 2'h3) pkts <= pkts + 8'h01;
            idx <= idx + 2'h1;
        end
    end
endmodule
`default_nettype wire

/* File: testbench/csi2_vc_datatype_mapper_tb_top.sv */
// bench for the csi-2 labelling block
`timescale 1ns/1ns
`default_nettype none
module csi2_vc_datatype_mapper_tb_top;
    logic clk = 0, link_clk = 0, rst_b = 0, reg_wr = 0, reg_rd = 0, sel = 0, rv, pll, auto;
    logic [7:0] addr = 8'h00, wd = 8'h00, rdat, tb, pkts, tmhz, ecs;
    logic [1:0] cv = 0, fsy = 0, lsy = 0, pix = 0, rdy, rate;
    logic [1:0][1:0] vc = 0;
    logic [1:0][5:0] dt = 0;
    logic [1:0][15:0] wc = 0;
    csi2_vc_map_pkg::rx_mode_e [1:0] mode = {csi2_vc_map_pkg::MODE_CSI2,
        csi2_vc_map_pkg::MODE_RAW10};
    logic [11:0] mbps;
    logic [7:0][6:0] tim;
    logic [23:0] hdr;
    logic tbv, tps, tpl;
    logic [7:0] rsel[3] = '{8'h00, 8'h02, 8'h03};
    logic [23:0] mb[3] = '{24'h00_0640, 24'h00_0320, 24'h00_0190};
    logic [7:0] tv[8] = '{8'h83, 8'h8d, 8'h87, 8'h87, 8'h83, 8'h86, 8'h84, 8'h86};
    int errors = 0, compares = 0;
    initial forever #20 clk = ~clk;
    initial begin
        #7;
        forever #80 link_clk = ~link_clk;
    end
    csi2_vc_datatype_mapper csi2_vc_datatype_mapper_inst (.clk(clk), .rst_b(rst_b),
        .link_clk(link_clk), .reg_addr(addr), .reg_wdata(wd), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_port_sel(sel), .reg_rdata(rdat), .reg_rvalid(rv), .rx_mode(mode),
        .csi_pkt_valid(cv), .csi_pkt_ready(rdy), .csi_pkt_vc(vc), .csi_pkt_dt(dt),
        .csi_pkt_wc(wc), .raw_frame_sync(fsy), .raw_line_sync(lsy), .raw_pixel_valid(pix),
        .tx_lane_rate(rate), .pll_low_ref(pll), .lane_rate_mbps(mbps), .timer_ref_mhz(tmhz),
        .tx_timing(tim), .tx_timing_auto(auto), .tx_byte(tb), .tx_byte_valid(tbv),
        .tx_pkt_start(tps), .tx_pkt_long(tpl));
    csi2_rx_model csi2_rx_model_inst (.link_clk(link_clk), .tx_byte(tb), .tx_byte_valid(tbv),
        .tx_pkt_start(tps), .hdr(hdr), .ecc(ecs), .pkts(pkts));
    task give_verdict;
        $display("compares %0d errors %0d", compares, errors);
        if (errors == 0 && compares > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    task lost(input string n);
        errors++;
        $display("unexpected %s exp done got timeout", n);
        give_verdict;
    endtask
    function automatic logic [7:0] ecc_of(input logic [23:0] h);
        ecc_of = 8'h00;
        for (int i = 0; i < 6; i++) ecc_of[i] = ^(h & csi2_vc_map_pkg::ECC_MASK[i]);
    endfunction
    task line4;
        @(posedge clk) lsy[0] <= 1'b1;
        pix[0] <= 1'b1;
        repeat (4) @(posedge clk);
        pix[0] <= 1'b0;
        lsy[0] <= 1'b0;
    endtask
    task chk(input string n, input logic [23:0] e, input logic [23:0] g);
        compares++;
        if (e !== g) begin
            $display("unexpected %s exp %h got %h", n, e, g);
            errors++;
        end
    endtask
    task wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        reg_wr <= 1'b1;
        addr <= a;
        wd <= d;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask
    task rd(input logic [7:0] a, input logic [7:0] e);
        @(posedge clk);
        reg_rd <= 1'b1;
        addr <= a;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1 chk("rdata", {16'h0000, e}, {16'h0000, rdat});
    endtask
    task hdr_wait(input logic [7:0] n, input logic [23:0] e);
        for (int i = 0; i < 400 && pkts !== n; i++) @(posedge clk);
        if (pkts !== n) begin
            lost("header");
        end else begin
            chk("header", e, hdr);
            chk("ecc", {16'h0000, ecc_of(e)}, {16'h0000, ecs});
        end
    endtask
    initial begin
        repeat (20) @(posedge clk);
        rst_b <= 1'b1;
        rd(8'h72, 8'he4);
        rd(8'h55, 8'h00);
        wr(8'h70, 8'h6b);
        rd(8'h70, 8'h6b);
        @(posedge clk) fsy[0] <= 1'b1;
        hdr_wait(8'h01, 24'h00_0040);
        line4;
        hdr_wait(8'h02, 24'h00_056b);
        @(posedge clk) fsy[0] <= 1'b0;
        hdr_wait(8'h03, 24'h00_0041);
        wr(8'h71, 8'h9c);
        @(posedge clk) mode[0] <= csi2_vc_map_pkg::MODE_RAW12;
        line4;
        hdr_wait(8'h04, 24'h00_069c);
        @(posedge clk) sel <= 1'b1;
        wr(8'h72, 8'he6);
        @(posedge clk) sel <= 1'b0;
        rd(8'h72, 8'he4);
        @(posedge clk) dt[1] <= 6'h2a;
        wc[1] <= 16'h0100;
        cv[1] <= 1'b1;
        for (int i = 0; i < 50; i++) @(negedge clk) if (rdy[1]) break;
        if (rdy[1] !== 1'b1) begin
            lost("ready");
        end
        @(posedge clk) cv[1] <= 1'b0;
        hdr_wait(8'h05, 24'h01_00aa);
        for (int i = 0; i < 3; i++) begin
            wr(8'h1f, rsel[i]);
            repeat (3) @(posedge clk);
            chk("mbps", mb[i], {12'h000, mbps});
            chk("rate", {16'h0000, rsel[i]}, {22'h00_0000, rate});
        end
        chk("pll", 24'h00_0001, {23'h00_0000, pll});
        chk("timer", 24'h00_0019, {16'h0000, tmhz});
        wr(8'hb0, 8'h02);
        wr(8'hb1, 8'h40);
        for (int i = 0; i < 8; i++) wr(8'hb2, tv[i]);
        repeat (2) @(posedge clk);
        chk("timing", 24'h00_000d, {17'h0_0000, tim[1]});
        chk("auto", 24'h00_0000, {23'h00_0000, auto});
        wr(8'hb0, 8'h00);
        wr(8'hb1, 8'h40);
        rd(8'hb2, 8'h83);
        give_verdict;
    end
endmodule
`default_nettype wire

/* File: testbench/csi2_vc_map_asserts.sv */
// port assertions for the csi-2 labelling block
`timescale 1ns/1ns
`default_nettype none
module csi2_vc_map_asserts (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic link_clk,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic reg_rvalid,
    input wire logic [1:0] tx_lane_rate,
    input wire logic pll_low_ref,
    input wire logic [11:0] lane_rate_mbps,
    input wire logic tx_timing_auto,
    input wire logic [7:0] tx_byte,
    input wire logic tx_byte_valid,
    input wire logic tx_pkt_start,
    input wire logic tx_pkt_long
);
    chk_read_answer: assert property (@(posedge clk) disable iff (!rst_b)
        reg_rd && !reg_wr |=> reg_rvalid) else $error("read not answered");
    chk_low_ref_pll: assert property (@(posedge clk) disable iff (!rst_b)
        tx_lane_rate == 2'b11 [*2] |-> pll_low_ref) else $error("pll not retuned");
    chk_full_rate: assert property (@(posedge clk) disable iff (!rst_b)
        tx_lane_rate == 2'b00 [*2] |-> lane_rate_mbps == 12'h640) else $error("full rate");
    chk_half_rate: assert property (@(posedge clk) disable iff (!rst_b)
        tx_lane_rate == 2'b10 [*2] |-> lane_rate_mbps == 12'h320) else $error("half rate");
    chk_quarter_manual: assert property (@(posedge clk) disable iff (!rst_b)
        tx_lane_rate == 2'b11 [*2] |-> !tx_timing_auto) else $error("auto at quarter");
    chk_header_burst: assert property (@(posedge link_clk) disable iff (!rst_b)
        tx_pkt_start |-> tx_byte_valid [*4]) else $error("header burst short");
    chk_start_single: assert property (@(posedge link_clk) disable iff (!rst_b)
        tx_pkt_start |=> !tx_pkt_start [*3]) else $error("start repeated");
    chk_long_type: assert property (@(posedge link_clk) disable iff (!rst_b)
        tx_pkt_start |-> tx_pkt_long == (tx_byte[5:0] > 6'h0f)) else $error("long flag");
    cover property (@(posedge link_clk) tx_pkt_start && tx_pkt_long);
    cover property (@(posedge link_clk) tx_pkt_start && !tx_pkt_long);
    cover property (@(posedge clk) pll_low_ref && !tx_timing_auto);
endmodule
bind csi2_vc_datatype_mapper csi2_vc_map_asserts csi2_vc_map_asserts_inst (.clk, .rst_b,
    .link_clk, .reg_wr, .reg_rd, .reg_rvalid, .tx_lane_rate, .pll_low_ref, .lane_rate_mbps,
    .tx_timing_auto, .tx_byte, .tx_byte_valid, .tx_pkt_start, .tx_pkt_long);
`default_nettype wire
